/* File: design/ffce_consts.svh */
// Constants for the floppy FIFO command engine
// Function
// - Sixteen-byte data FIFO, threshold set by software
// - All parameter and data bytes cross the FIFO, except verify data with FIFO on
// - Host transfers only when permit or DMA request, and direction, allow
// - FIFO comes up disabled after hard reset, or software reset without lock
// - Service request raised at programmed threshold level
// - FIFO treated disabled during command byte intake
// - FIFO flushed on entering execution
// - Overrun or underrun aborts command and transfer
// - Aborted write pads sector with 00, valid CRC
// - Host drains read FIFO before result phase
// - Specify selects DMA; request during data commands
// - DMA grant selects FIFO regardless of address
// - Grant alone pops in byte-mode read verify
// - Verify command with FIFO on needs no DMA
// - Separator locks, window splits clock and data bits
// - Separator cycle nominally twelve clocks, pulse-corrected
// - Every pulse yields read and window strobes
// - Pulseless cycles follow integrator-tracked speed
// - Perpendicular command, forces one megabit rate
// - Command, execution, result phases in order
// - Lock keeps FIFO settings across software reset
// - Step direction: 0 outward, 1 inward
`ifndef FFCE_CONSTS_SVH
`define FFCE_CONSTS_SVH
`define FFCE_FIFO_DEPTH 16
`define FFCE_A_STATUS 2'h0
`define FFCE_A_DATA 2'h1
`define FFCE_A_CTRL 2'h2
`define FFCE_MSR_PERMIT 7
`define FFCE_MSR_DIR 6
`define FFCE_MSR_NDMA 5
`define FFCE_MSR_BUSY 4
`define FFCE_CTL_SRST 0
`define FFCE_OP_READ 8'h06
`define FFCE_OP_WRITE 8'h05
`define FFCE_OP_VERIFY 8'h16
`define FFCE_OP_SPECIFY 8'h03
`define FFCE_OP_SETUP 8'h13
`define FFCE_OP_PERP 8'h12
`define FFCE_OP_RSEEK 8'h8F
`define FFCE_SPEC_ND 0
`define FFCE_SET_LOCK 7
`define FFCE_SET_FIFO_ON 5
`define FFCE_PERP_ON 0
`define FFCE_DIR_BIT 6
`define FFCE_RST_FIFO_ON 1'b0
`define FFCE_RST_LEVEL 4'h0
`define FFCE_RST_PTRK 8'h00
`define FFCE_ST_OK 8'h00
`define FFCE_ST_ABORT 8'h40
`define FFCE_ST_INVALID 8'h80
`define FFCE_PAD_BYTE 8'h00
`define FFCE_CRC_INIT 16'hFFFF
`define FFCE_CRC_POLY 16'h1021
`define FFCE_CLK_NS 25
`define FFCE_BIT_NS_1M 1000
`define FFCE_BIT_NS_500K 2000
`define FFCE_DDS_NOM 12
`define FFCE_DDS_MIN 8
`define FFCE_DDS_MAX 16
`endif

/* File: design/ffce_pkg.sv */
// Types for the two ends of the floppy FIFO command engine: phases for the controller end, states for the host end
package ffce_pkg;
  typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RES} ffce_phase_t;
  typedef enum logic [2:0] {H_POLL, H_WAIT, H_LOOK, H_DRD, H_CAP} ffce_hstate_t;
endpackage : ffce_pkg

/* File: design/ffce_if.sv */
// Host bus and DMA handshake between host end and controller end
`timescale 1ns/100ps
`default_nettype none
interface ffce_if;
  logic [1:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       dma_request_out;
  logic       dma_grant_n;
  modport dev  (input addr, wr, rd, wdata, dma_grant_n, output rdata, dma_request_out);
  modport host (output addr, wr, rd, wdata, dma_grant_n, input rdata, dma_request_out);
endinterface : ffce_if
`default_nettype wire

/* File: design/ffce_host.sv */
// Host end: polls main status and moves bytes by program or DMA
`timescale 1ns/100ps
`default_nettype none
`include "ffce_consts.svh"
module ffce_host
  import ffce_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_ce,
  // Bus to the controller
  ffce_if.host            bus,
  // User side
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_tx_ready,
  input  wire logic       i_dma_verify,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_byte
);
  ffce_hstate_t st_reg;
  logic [1:0]   addr_reg;
  logic         wr_reg, rd_reg, gnt_n_reg, got_reg;
  logic [7:0]   wdata_reg;

  // Status decode, valid in the look state
  wire permit  = bus.rdata[`FFCE_MSR_PERMIT];
  wire dir     = bus.rdata[`FFCE_MSR_DIR];
  wire dreq    = bus.dma_request_out;
  wire look    = (st_reg == H_LOOK);
  wire take_wr = look & !dir & (permit | dreq) & i_tx_valid;
  wire take_rd = look & dir & (permit | dreq);
  wire pseudo  = dreq & i_dma_verify;

  assign o_tx_ready = take_wr & i_ce;
  assign bus.addr = addr_reg;
  // Strobes and grant masked while frozen, so a held strobe acts once
  assign bus.wr = wr_reg & i_ce;
  assign bus.rd = rd_reg & i_ce;
  assign bus.wdata = wdata_reg;
  assign bus.dma_grant_n = gnt_n_reg | !i_ce;

  // Poll, look, transfer loop
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= H_POLL;
      addr_reg <= `FFCE_A_STATUS;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      gnt_n_reg <= 1'b1;
      got_reg <= 1'b0;
      wdata_reg <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_byte <= 8'h00;
    end else if (i_ce) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      gnt_n_reg <= 1'b1;
      o_rx_valid <= 1'b0;
      unique case (st_reg)
        H_POLL: begin
          rd_reg <= 1'b1;
          addr_reg <= `FFCE_A_STATUS;
          st_reg <= H_WAIT;
        end
        H_WAIT: st_reg <= H_LOOK;
        H_LOOK: begin
          addr_reg <= `FFCE_A_DATA;
          gnt_n_reg <= !dreq;
          if (take_wr) begin
            wr_reg <= 1'b1;
            wdata_reg <= i_tx_byte;
            st_reg <= H_POLL;
          end else if (take_rd) begin
            rd_reg <= !pseudo;
            got_reg <= !pseudo;
            st_reg <= H_DRD;
          end else begin
            gnt_n_reg <= 1'b1;
            st_reg <= H_POLL;
          end
        end
        H_DRD: st_reg <= H_CAP;
        H_CAP: begin
          o_rx_valid <= got_reg;
          o_rx_byte <= bus.rdata;
          st_reg <= H_POLL;
        end
      endcase
    end
  end
endmodule : ffce_host
`default_nettype wire

/* File: design/ffce_dev.sv */
// Controller end: FIFO, command phases, DMA, separator, write serializer
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ffce_consts.svh"
module ffce_dev
  import ffce_pkg::*;
#(
  parameter int DEPTH = `FFCE_FIFO_DEPTH
)(
  // Clock, reset, enable
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_ce,
  // Bus from the host
  ffce_if.dev       bus,
  // Drive side
  input  wire logic i_drive_read_stream,
  output logic      o_wr_stream,
  output logic      o_wr_gate,
  output logic      o_sep_read_strobe,
  output logic      o_read_window_strobe,
  output logic [7:0] o_clock_byte,
  output logic      o_step_inward,
  output logic      o_perp_mode,
  output logic [7:0] o_precomp_start_track
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int C1M = `FFCE_BIT_NS_1M / `FFCE_CLK_NS;
  localparam int C500K = `FFCE_BIT_NS_500K / `FFCE_CLK_NS;

  if (DEPTH < 16 || (1 << AW) != DEPTH) begin : g_chk
    $error("DEPTH must be a power of two of at least 16");
  end

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `FFCE_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_upd

  function automatic logic [1:0] pcount(input logic [7:0] op);
    case (op)
      `FFCE_OP_READ, `FFCE_OP_WRITE, `FFCE_OP_VERIFY: pcount = 2'd1;
      `FFCE_OP_PERP, `FFCE_OP_RSEEK:                  pcount = 2'd1;
      `FFCE_OP_SPECIFY:                               pcount = 2'd2;
      `FFCE_OP_SETUP:                                 pcount = 2'd3;
      default:                                        pcount = 2'd0;
    endcase
  endfunction : pcount

  logic [7:0]    mem [DEPTH];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [CW-1:0] cnt_reg;
  ffce_phase_t   ph_reg;
  logic [7:0]    op_reg, stat_reg, rdata_reg;
  logic [1:0]    pleft_reg, pidx_reg;
  logic [8:0]    len_reg;
  logic          done_reg, abort_reg, resl_reg;
  logic          fifo_on_reg, lock_reg, dma_reg, rate1m_reg;
  logic [3:0]    lvl_reg;
  logic [7:0]    ptrk_q;
  // Separator state
  logic          s1_reg, s2_reg, s3_reg, win_reg, seen_reg;
  logic [4:0]    dph_reg, spd_reg;
  logic [2:0]    dbc_reg;
  logic [7:0]    dsh_reg, csh_reg;
  // Write serializer state
  logic          wact_reg, wcrc_reg, wlast_reg;
  logic [6:0]    wcell_reg;
  logic [2:0]    wbit_reg;
  logic [7:0]    wsh_reg;
  logic [15:0]   crc_reg;

  // Bus decode
  wire dma_sel  = !bus.dma_grant_n;
  wire data_sel = dma_sel | (bus.addr == `FFCE_A_DATA);
  wire host_wr  = i_ce & bus.wr & data_sel;
  wire host_rd  = i_ce & bus.rd & data_sel;
  wire srst     = i_ce & bus.wr & !dma_sel & (bus.addr == `FFCE_A_CTRL)
                  & bus.wdata[`FFCE_CTL_SRST];
  wire [7:0] head = mem[rp_reg];

  // Phase and FIFO level decode
  wire is_rd   = (op_reg == `FFCE_OP_READ) | (op_reg == `FFCE_OP_VERIFY);
  wire x_rd    = (ph_reg == PH_EXEC) & is_rd;
  wire x_wr    = (ph_reg == PH_EXEC) & (op_reg == `FFCE_OP_WRITE);
  wire vfy_int = (op_reg == `FFCE_OP_VERIFY) & fifo_on_reg;
  wire empty   = (cnt_reg == '0);
  wire full    = (cnt_reg == CW'(DEPTH));
  wire [CW-1:0] thr = fifo_on_reg ? (CW'(lvl_reg) + CW'(1)) : CW'(1);
  wire rd_rdy  = (cnt_reg >= thr) | (done_reg & !empty);
  wire wr_rdy  = ((CW'(DEPTH) - cnt_reg) >= thr) & !done_reg & !abort_reg;
  wire dreq    = dma_reg & !vfy_int & (x_rd ? rd_rdy : (x_wr & wr_rdy));
  wire permit  = (ph_reg == PH_CMD) ? empty
               : (ph_reg == PH_RES) ? (resl_reg & !empty)
               : (!dma_reg & (x_rd ? rd_rdy : wr_rdy));
  wire dir     = x_rd | (ph_reg == PH_RES);
  wire [7:0] msr = {permit, dir, (ph_reg == PH_EXEC) & !dma_reg,
                    (ph_reg != PH_CMD) | (pleft_reg != 2'd0), 4'h0};

  // Separator pulse and cell decode
  wire pulse    = s2_reg & !s3_reg;
  wire [4:0] half = {1'b0, spd_reg[4:1]};
  wire cell_end = !pulse & (dph_reg == spd_reg - 5'd1);
  wire dds_byte = cell_end & win_reg & (dbc_reg == 3'd7);
  wire [7:0] dds_data = {dsh_reg[6:0], seen_reg};
  wire rx_byte  = i_ce & x_rd & dds_byte & !done_reg;
  wire ovr      = rx_byte & !vfy_int & full;

  // Write serializer byte load
  wire [6:0] wcyc  = rate1m_reg ? 7'(C1M) : 7'(C500K);
  wire wcell_end   = (wcell_reg == wcyc - 7'd1);
  wire wld   = i_ce & x_wr & !done_reg & (wact_reg ? (wcell_end & (wbit_reg == 3'd7)) : !empty);
  wire wdat  = (len_reg != 9'd0);
  wire undr  = wld & !wlast_reg & wdat & empty;
  wire [7:0] wbyte = !wdat ? (wcrc_reg ? crc_reg[7:0] : crc_reg[15:8])
                   : (empty | abort_reg) ? `FFCE_PAD_BYTE : head;

  // FIFO push and pop steering
  wire eng_pop = i_ce & (ph_reg == PH_CMD) & !empty;
  wire res_psh = i_ce & (ph_reg == PH_RES) & !resl_reg & empty;
  wire dds_psh = rx_byte & !vfy_int & !full;
  wire hw_psh  = host_wr & ((ph_reg == PH_CMD) | x_wr) & !full;
  wire psh     = hw_psh | dds_psh | res_psh;
  wire [7:0] psh_d = res_psh ? stat_reg : dds_psh ? dds_data : bus.wdata;
  wire pseudo  = i_ce & x_rd & dreq & dma_sel & !bus.rd & !fifo_on_reg;
  wire pop     = !empty & (eng_pop | pseudo | (wld & wdat & !abort_reg & !wlast_reg)
                 | (host_rd & (x_rd | ph_reg == PH_RES)));
  wire last_p  = eng_pop & (pleft_reg == 2'd1);
  wire go_exec = last_p & (pcount(op_reg) == 2'd1) & ((op_reg == `FFCE_OP_READ)
                 | (op_reg == `FFCE_OP_WRITE) | (op_reg == `FFCE_OP_VERIFY));

  assign bus.dma_request_out = dreq;
  assign bus.rdata = rdata_reg;
  assign o_precomp_start_track = ptrk_q;

  // FIFO storage, written on each push
  always_ff @(posedge i_clk) begin
    if (i_ce & psh) begin
      mem[wp_reg] <= psh_d;
    end
  end

  // FIFO pointers, flushed on entry to execution
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      rdata_reg <= 8'h00;
    end else if (i_ce) begin
      if (bus.rd) rdata_reg <= (data_sel ? head : msr);
      if (srst | go_exec) begin
        wp_reg <= '0;
        rp_reg <= '0;
        cnt_reg <= '0;
      end else begin
        wp_reg <= wp_reg + AW'(psh);
        rp_reg <= rp_reg + AW'(pop);
        cnt_reg <= cnt_reg + CW'(psh) - CW'(pop);
      end
    end
  end

  // Command engine: intake, execution, result
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ph_reg <= PH_CMD;
      {op_reg, stat_reg} <= 16'h0000;
      {pleft_reg, pidx_reg} <= 4'h0;
      len_reg <= 9'h000;
      {done_reg, abort_reg, resl_reg, lock_reg, dma_reg, rate1m_reg} <= 6'h00;
      fifo_on_reg <= `FFCE_RST_FIFO_ON;
      lvl_reg <= `FFCE_RST_LEVEL;
      ptrk_q <= `FFCE_RST_PTRK;
      {o_step_inward, o_perp_mode} <= 2'b00;
    end else if (i_ce) begin
      if (srst) begin
        ph_reg <= PH_CMD;
        pleft_reg <= 2'd0;
        {done_reg, abort_reg, resl_reg} <= 3'b000;
        if (!lock_reg) begin
          fifo_on_reg <= `FFCE_RST_FIFO_ON;
          lvl_reg <= `FFCE_RST_LEVEL;
          ptrk_q <= `FFCE_RST_PTRK;
        end
      end else unique case (ph_reg)
        PH_CMD: if (eng_pop) begin
          if (pleft_reg == 2'd0) begin
            op_reg <= head;
            pleft_reg <= pcount(head);
            pidx_reg <= 2'd0;
            if (pcount(head) == 2'd0) begin
              stat_reg <= `FFCE_ST_INVALID;
              ph_reg <= PH_RES;
            end
          end else begin
            pleft_reg <= pleft_reg - 2'd1;
            pidx_reg <= pidx_reg + 2'd1;
            unique case (op_reg)
              `FFCE_OP_SPECIFY: if (pidx_reg == 2'd1) dma_reg <= !head[`FFCE_SPEC_ND];
              `FFCE_OP_SETUP: unique case (pidx_reg)
                2'd0: lock_reg <= head[`FFCE_SET_LOCK];
                2'd1: {fifo_on_reg, lvl_reg} <= {head[`FFCE_SET_FIFO_ON], head[3:0]};
                default: ptrk_q <= head;
              endcase
              `FFCE_OP_PERP: begin
                o_perp_mode <= head[`FFCE_PERP_ON];
                if (head[`FFCE_PERP_ON]) rate1m_reg <= 1'b1;
              end
              `FFCE_OP_RSEEK: o_step_inward <= head[`FFCE_DIR_BIT];
              default: len_reg <= {head == 8'h00, head};
            endcase
            if (go_exec) begin
              ph_reg <= PH_EXEC;
              {done_reg, abort_reg} <= 2'b00;
            end
          end
        end
        PH_EXEC: begin
          if (rx_byte) begin
            len_reg <= len_reg - 9'd1;
            if (ovr) abort_reg <= 1'b1;
            if (ovr | len_reg == 9'd1) done_reg <= 1'b1;
          end
          if (wld & !wlast_reg & wdat) len_reg <= len_reg - 9'd1;
          if (undr) abort_reg <= 1'b1;
          if (wld & wlast_reg) done_reg <= 1'b1;
          if (done_reg & (x_wr | empty)) begin
            stat_reg <= abort_reg ? `FFCE_ST_ABORT : `FFCE_ST_OK;
            ph_reg <= PH_RES;
          end
        end
        PH_RES: begin
          if (res_psh) resl_reg <= 1'b1;
          else if (resl_reg & empty) begin
            resl_reg <= 1'b0;
            pleft_reg <= 2'd0;
            ph_reg <= PH_CMD;
          end
        end
        default: ph_reg <= PH_CMD;
      endcase
    end
  end

  // Write serializer with zero pad and CRC tail
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {wact_reg, wcrc_reg, wlast_reg} <= 3'b000;
      {wcell_reg, wbit_reg, wsh_reg} <= 18'h00000;
      crc_reg <= `FFCE_CRC_INIT;
    end else if (i_ce) begin
      if (!x_wr | done_reg) begin
        {wact_reg, wcrc_reg, wlast_reg} <= 3'b000;
        wcell_reg <= 7'd0;
        wbit_reg <= 3'd0;
        crc_reg <= `FFCE_CRC_INIT;
      end else begin
        wcell_reg <= wcell_end ? 7'd0 : wcell_reg + 7'd1;
        if (wact_reg & wcell_end) wbit_reg <= wbit_reg + 3'd1;
        if (wld) begin
          wact_reg <= 1'b1;
          wcell_reg <= 7'd0;
          wsh_reg <= wbyte;
          if (wdat) crc_reg <= crc_upd(crc_reg, wbyte);
          else if (!wcrc_reg) wcrc_reg <= 1'b1;
          else wlast_reg <= 1'b1;
        end else if (wact_reg & wcell_end) begin
          wsh_reg <= {wsh_reg[6:0], 1'b0};
        end
      end
    end
  end
  assign o_wr_stream = wsh_reg[7] & wact_reg;
  assign o_wr_gate = wact_reg;

  // Digital separator: sync, phase, speed integrator
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {s1_reg, s2_reg, s3_reg, win_reg, seen_reg} <= 5'h00;
      dph_reg <= 5'd0;
      spd_reg <= 5'(`FFCE_DDS_NOM);
      dbc_reg <= 3'd0;
      {dsh_reg, csh_reg, o_clock_byte} <= 24'h000000;
      {o_sep_read_strobe, o_read_window_strobe} <= 2'b00;
    end else if (i_ce) begin
      s1_reg <= i_drive_read_stream;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      o_sep_read_strobe <= pulse;
      o_read_window_strobe <= pulse;
      if (pulse) begin
        dph_reg <= half + 5'd1;
        seen_reg <= 1'b1;
        if (dph_reg > half && spd_reg < 5'(`FFCE_DDS_MAX)) spd_reg <= spd_reg + 5'd1;
        if (dph_reg < half && spd_reg > 5'(`FFCE_DDS_MIN)) spd_reg <= spd_reg - 5'd1;
      end else if (cell_end) begin
        dph_reg <= 5'd0;
        seen_reg <= 1'b0;
        win_reg <= !win_reg;
        if (win_reg) begin
          dsh_reg <= dds_data;
          dbc_reg <= dbc_reg + 3'd1;
          if (dbc_reg == 3'd7) o_clock_byte <= csh_reg;
        end else begin
          csh_reg <= {csh_reg[6:0], seen_reg};
        end
      end else begin
        dph_reg <= dph_reg + 5'd1;
      end
    end
  end
endmodule : ffce_dev
`default_nettype wire

/* File: test/ffce_asserts.sv */
// Interface checker for the floppy FIFO command engine
`timescale 1ns/100ps
`default_nettype none
`include "ffce_consts.svh"
module ffce_asserts
  import ffce_pkg::*;
(
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  // Interface signals
  input wire logic [1:0] addr,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       dma_request_out,
  input wire logic       dma_grant_n
);
  logic       st_rd_reg;
  logic       spec_reg;
  logic [7:0] st_reg;
  // Latest status byte and programmed data access
  wire  [7:0] st_now = st_rd_reg ? rdata : st_reg;
  wire        pio    = dma_grant_n && addr == `FFCE_A_DATA;
  // Track status reads and whether a specify byte went by
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_rd_reg <= 1'b0;
      st_reg    <= 8'h00;
      spec_reg  <= 1'b0;
    end else begin
      st_rd_reg <= rd && addr == `FFCE_A_STATUS;
      st_reg    <= st_now;
      if (wr && pio && wdata == `FFCE_OP_SPECIFY) spec_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  strobe_excl_a: assert property (!(wr && rd))
    else $error("wr and rd high together");
  wr_pulse_a: assert property (wr |=> !wr)
    else $error("write strobe longer than one cycle");
  rd_pulse_a: assert property (rd |=> !rd)
    else $error("read strobe longer than one cycle");
  cmd_write_a: assert property (wr && pio |-> st_now[7] && !st_now[6])
    else $error("data write without permit toward device");
  data_read_a: assert property (rd && pio |-> st_now[7] && st_now[6])
    else $error("data read without permit toward host");
  rdata_hold_a: assert property (!rd && dma_grant_n |=> $stable(rdata))
    else $error("read data changed without a read");
  req_spec_a: assert property (dma_request_out |-> spec_reg)
    else $error("dma request before any specify");
  grant_req_a: assert property ($fell(dma_grant_n) |->
      $past(dma_request_out) || $past(dma_request_out, 2) || $past(dma_request_out, 3))
    else $error("dma grant without request");
  grant_pulse_a: assert property (!dma_grant_n |=> dma_grant_n)
    else $error("dma grant longer than one cycle");
endmodule : ffce_asserts
`default_nettype wire

/* File: test/test_floppy_fifo_command_engine.sv */
// Bench joining host end and controller end over the interface
`timescale 1ns/100ps
`default_nettype none
`include "ffce_consts.svh"
module test_floppy_fifo_command_engine
  import ffce_pkg::*;
;
  logic        clk, arst_n, hce, tx_v, dverify, rs, pon;
  logic        tx_rdy, rx_v, ws, wg, s_rd, s_win, step_in, perp;
  logic [7:0]  tx_b, rx_b, clk_b, ptrk, res_b;
  int unsigned pc, npul, ns_rd, ns_win, nreq, cyc, fail_count, checks_done;
  // ---------------------------------------------
  // Instances
  // ---------------------------------------------
  ffce_if bus ();
  ffce_host i_ffce_host (.i_clk(clk), .i_arst_n(arst_n), .i_ce(hce), .bus(bus),
    .i_tx_valid(tx_v), .i_tx_byte(tx_b), .o_tx_ready(tx_rdy), .i_dma_verify(dverify),
    .o_rx_valid(rx_v), .o_rx_byte(rx_b));
  ffce_dev #(.DEPTH(`FFCE_FIFO_DEPTH)) i_ffce_dev (.i_clk(clk), .i_arst_n(arst_n),
    .i_ce(1'b1), .bus(bus), .i_drive_read_stream(rs), .o_wr_stream(ws), .o_wr_gate(wg),
    .o_sep_read_strobe(s_rd), .o_read_window_strobe(s_win), .o_clock_byte(clk_b),
    .o_step_inward(step_in), .o_perp_mode(perp), .o_precomp_start_track(ptrk));
  ffce_asserts i_ffce_asserts (.i_clk(clk), .i_arst_n(arst_n), .addr(bus.addr),
    .wr(bus.wr), .rd(bus.rd), .wdata(bus.wdata), .rdata(bus.rdata),
    .dma_request_out(bus.dma_request_out), .dma_grant_n(bus.dma_grant_n));
  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Read pulses every 12 cycles, strobe counts, timeout
  always @(posedge clk) begin
    pc <= (pc == 11) ? 0 : pc + 1;
    rs <= pon && pc < 2;
    if (pon && pc == 0) npul <= npul + 1;
    if (s_rd === 1'b1) ns_rd <= ns_rd + 1;
    if (s_win === 1'b1) ns_win <= ns_win + 1;
    if (bus.dma_request_out === 1'b1) nreq <= nreq + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      wrap_up;
    end
  end
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    tx_v <= 1'b1;
    tx_b <= b;
    do @(negedge clk); while (tx_rdy !== 1'b1);
    @(posedge clk);
    tx_v <= 1'b0;
  endtask : send
  task automatic recv(output logic [7:0] b);
    do @(negedge clk); while (rx_v !== 1'b1);
    b = rx_b;
  endtask : recv
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = `FFCE_CRC_INIT;
    foreach (q[k]) begin
      c = c ^ {q[k], 8'h00};
      repeat (8) c = c[15] ? (c << 1) ^ `FFCE_CRC_POLY : c << 1;
    end
    return c;
  endfunction : crc16
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_step;
    send(`FFCE_OP_RSEEK);
    send(8'h40);
    repeat (20) @(negedge clk);
    check("step in", step_in, 1);
    send(`FFCE_OP_RSEEK);
    send(8'h00);
    repeat (20) @(negedge clk);
    check("step out", step_in, 0);
  endtask : t_step
  task automatic t_write(input int len, input int nsend);
    logic [7:0] q[$];
    logic [7:0] b;
    logic [7:0] r;
    logic [15:0] c;
    for (int i = 0; i < len; i++) q.push_back(i < nsend ? 8'hA5 ^ 8'(i * 7) : `FFCE_PAD_BYTE);
    c = crc16(q);
    q.push_back(c[15:8]);
    q.push_back(c[7:0]);
    fork
      begin
        send(`FFCE_OP_WRITE);
        send(8'(len));
        for (int i = 0; i < nsend; i++) send(q[i]);
      end
      begin
        do @(negedge clk); while (wg !== 1'b1);
        repeat (40) @(negedge clk);
        foreach (q[k]) begin
          for (int j = 7; j >= 0; j--) begin
            b[j] = ws;
            repeat (80) @(negedge clk);
          end
          check("write stream byte", b, q[k]);
        end
      end
      // Result byte arrives while the last bit is still being watched
      begin
        recv(r);
      end
    join
    check("write result", r, nsend < len ? `FFCE_ST_ABORT : `FFCE_ST_OK);
  endtask : t_write
  task automatic t_read(input logic [7:0] op, input logic [7:0] len, input int ndata,
                        input logic [7:0] res, input bit stall, input bit dma, input bit vfy);
    logic [7:0] b;
    int unsigned p0, r0, w0, q0;
    p0 = npul;
    r0 = ns_rd;
    w0 = ns_win;
    q0 = nreq;
    // Let the separator lock and fill its shifters before the command
    @(posedge clk);
    pon <= 1'b1;
    dverify <= vfy;
    repeat (300) @(posedge clk);
    send(op);
    send(len);
    if (stall) begin
      // Let the length byte reach the controller before freezing
      repeat (2) @(posedge clk);
      hce <= 1'b0;
      repeat (3600) @(posedge clk);
      hce <= 1'b1;
    end
    for (int i = 0; i < ndata; i++) begin
      recv(b);
      check("read byte", b, 8'hFF);
    end
    if (ndata > 0) check("clock byte", clk_b, 8'hFF);
    recv(b);
    check("read result", b, res);
    @(posedge clk);
    pon <= 1'b0;
    dverify <= 1'b0;
    repeat (20) @(negedge clk);
    check("read strobes", 16'(ns_rd - r0), 16'(npul - p0));
    check("window strobes", 16'(ns_win - w0), 16'(npul - p0));
    check("dma used", nreq != q0, dma);
  endtask : t_read
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    {arst_n, tx_v, dverify, rs, pon, tx_b} = '0;
    hce = 1'b1;
    {pc, npul, ns_rd, ns_win, nreq, cyc, fail_count, checks_done} = '0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    check("reset outputs", {wg, perp, bus.dma_request_out, 5'h00, ptrk},
          {8'h00, `FFCE_RST_PTRK});
    t_step;
    send(8'h00);
    recv(res_b);
    check("unknown opcode", res_b, `FFCE_ST_INVALID);
    send(`FFCE_OP_SPECIFY);
    send(8'h00);
    send(8'h00);
    t_write(2, 2);
    t_write(3, 1);
    t_read(`FFCE_OP_READ, 8'd2, 0, `FFCE_ST_OK, 0, 1, 1);
    t_read(`FFCE_OP_READ, 8'd2, 2, `FFCE_ST_OK, 0, 1, 0);
    send(`FFCE_OP_SPECIFY);
    send(8'h00);
    send(8'h01);
    send(`FFCE_OP_SETUP);
    send(8'h00);
    send(8'h2F);
    send(8'h2A);
    repeat (20) @(negedge clk);
    check("precomp track", ptrk, 8'h2A);
    t_read(`FFCE_OP_VERIFY, 8'd2, 0, `FFCE_ST_OK, 0, 0, 0);
    t_read(`FFCE_OP_READ, 8'd20, `FFCE_FIFO_DEPTH, `FFCE_ST_ABORT, 1, 0, 0);
    send(`FFCE_OP_PERP);
    send(8'h01);
    repeat (20) @(negedge clk);
    check("perpendicular", perp, 1);
    wrap_up;
  end
endmodule : test_floppy_fifo_command_engine
`default_nettype wire
